// >>> lsrm_pkg.sv
// Overview of operation
// (R1) monitoring is active straight out of reset, no software action needed.
// (R2) power disable bit at 0 observes the comparator; at 1 monitoring is off.
// (R3) trip reset disable at 1 never forces reset; only the flag reports.
// (R4) reset asserts after 9 consecutive cycles at or below falling level.
// (R5) reset holds until supply above rising level for one cycle.
// (R6) a monitor reset also drives the external reset pin low.
// (R7) flag stays 0 under 32 crystal clocks low, is 1 after 40.
// (R8) flag clears above rising level, keeps value between the two levels.
// (R9) any reset clears the flag; software writes to it have no effect.
// (R10) the monitor never raises a processor interrupt request.
// (R11) in wait mode an enabled monitor works; its reset ends wait mode.
// (R12) in stop mode it works only when stop enable is set.
// (R13) the crystal clock count runs at the crystal oscillator frequency.
// (R14) comparator results arrive as two synchronised level signals.
package lsrm_pkg;

    // register byte addresses
    localparam logic [3:0] LSRM_ADDR_OPTION = 4'h0;
    localparam logic [3:0] LSRM_ADDR_STATUS = 4'h4;
    localparam logic [3:0] LSRM_ADDR_EVENT  = 4'h8;
    localparam logic [3:0] LSRM_ADDR_MASK   = 4'hC;

    // option_register_a field positions
    localparam int LSRM_BIT_PWR_DIS  = 0;
    localparam int LSRM_BIT_RST_DIS  = 1;
    localparam int LSRM_BIT_STOP_EN  = 2;

    // supply_status_register field positions
    localparam int LSRM_BIT_LOW_FLAG = 0;
    localparam int LSRM_BIT_HOLD     = 1;
    localparam int LSRM_BIT_BELOW    = 2;
    localparam int LSRM_BIT_ABOVE    = 3;

    // event field positions
    localparam int LSRM_EV_FLAG_SET  = 0;
    localparam int LSRM_EV_RESET     = 1;

    // reset values
    localparam logic [2:0] LSRM_OPTION_RST = 3'h0;
    localparam logic [1:0] LSRM_EVENT_RST  = 2'h0;
    localparam logic [1:0] LSRM_MASK_RST   = 2'h0;

    // reset filter: consecutive cpu cycles at or below falling level
    localparam logic [3:0] LSRM_TRIP_CYCLES  = 4'h9;
    // flag delay in crystal clocks, inside the 32 to 40 window
    localparam logic [5:0] LSRM_FLAG_CLOCKS  = 6'h24;

    localparam logic [1:0] LSRM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] LSRM_RESP_SLVERR = 2'h2;

endpackage

// >>> lsrm_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module lsrm_monitor
    import lsrm_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    // analogue comparator levels and crystal clock, asynchronous
    input  wire logic        below_falling,
    input  wire logic        above_rising,
    input  wire logic        crystal_clock,
    // low power state of the cpu, same clock domain
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    // system reset request, wake request, external pin and event line
    output logic             monitor_reset,
    output logic             wake_request,
    output logic             reset_pin_out,
    output logic             reset_pin_oe,
    output logic             event_irq,
    // axi4-lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // synchronisers: below, above, crystal clock
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic       xtal_prev_reg;
    logic       below_s;
    logic       above_s;
    logic       xtal_edge;

    // monitor state
    logic [3:0] trip_cnt_reg,  trip_cnt_next;
    logic [5:0] flag_cnt_reg,  flag_cnt_next;
    logic       hold_reg,      hold_next;
    logic       low_flag_reg,  low_flag_next;
    logic       active;

    // registers
    logic [2:0] option_reg,    option_next;
    logic [1:0] event_reg,     event_next;
    logic [1:0] mask_reg,      mask_next;
    logic [1:0] event_set;

    // bus state
    logic        aw_have_reg,  aw_have_next;
    logic [3:0]  aw_addr_reg,  aw_addr_next;
    logic        w_have_reg,   w_have_next;
    logic [31:0] w_data_reg,   w_data_next;
    logic [3:0]  w_strb_reg,   w_strb_next;
    logic        bvalid_reg,   bvalid_next;
    logic [1:0]  bresp_reg,    bresp_next;
    logic        rvalid_reg,   rvalid_next;
    logic [31:0] rdata_reg,    rdata_next;
    logic [1:0]  rresp_reg,    rresp_next;
    logic        wr_fire;
    logic        rd_fire;
    logic        wr_opt;
    logic        wr_mask;

    // two-stage synchronisers; only stage two is read by logic
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sync1_reg     <= 3'h0;
            sync2_reg     <= 3'h0;
            xtal_prev_reg <= 1'b0;
        end else begin
            sync1_reg     <= {crystal_clock, above_rising, below_falling};
            sync2_reg     <= sync1_reg;
            xtal_prev_reg <= sync2_reg[2];
        end
    end

    // synchronised comparator levels and crystal edge
    assign below_s   = sync2_reg[0]; // [R14]
    assign above_s   = sync2_reg[1]; // [R14]
    assign xtal_edge = sync2_reg[2] & ~xtal_prev_reg; // [R13]

    // monitor enable from power bit and stop mode
    always_comb begin
        active = ~option_reg[LSRM_BIT_PWR_DIS]; // [R2] [R1]
        if (stop_mode && !option_reg[LSRM_BIT_STOP_EN]) begin
            active = 1'b0; // [R12]
        end
    end

    // reset filter, reset hold and supply low flag
    always_comb begin
        trip_cnt_next = trip_cnt_reg;
        flag_cnt_next = flag_cnt_reg;
        hold_next     = hold_reg;
        low_flag_next = low_flag_reg;
        if (!active) begin
            trip_cnt_next = 4'h0;
            flag_cnt_next = 6'h0;
        end else begin
            // consecutive cycles low, any high cycle restarts
            if (!below_s) begin
                trip_cnt_next = 4'h0; // [R4]
            end else if (trip_cnt_reg != LSRM_TRIP_CYCLES) begin
                trip_cnt_next = trip_cnt_reg + 4'h1;
            end
            // crystal clocks spent low
            if (!below_s) begin
                flag_cnt_next = 6'h0;
            end else if (xtal_edge && flag_cnt_reg != LSRM_FLAG_CLOCKS) begin
                flag_cnt_next = flag_cnt_reg + 6'h1; // [R7]
            end
            if (flag_cnt_reg == LSRM_FLAG_CLOCKS) begin
                low_flag_next = 1'b1; // [R7]
            end
            if (above_s) begin
                low_flag_next = 1'b0; // [R8]
            end
            if (!option_reg[LSRM_BIT_RST_DIS]
                && trip_cnt_reg == LSRM_TRIP_CYCLES) begin
                hold_next = 1'b1; // [R3] [R4] [R11] [R12]
            end
        end
        // a single cycle above the rising level ends the hold
        if (hold_reg && above_s) begin
            hold_next     = 1'b0; // [R5]
            trip_cnt_next = 4'h0;
        end
        // the system is in reset while held, so the flag clears
        if (hold_reg) begin
            low_flag_next = 1'b0; // [R9]
            flag_cnt_next = 6'h0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            trip_cnt_reg <= 4'h0;
            flag_cnt_reg <= 6'h0;
            hold_reg     <= 1'b0;
            low_flag_reg <= 1'b0; // [R9]
        end else begin
            trip_cnt_reg <= trip_cnt_next;
            flag_cnt_reg <= flag_cnt_next;
            hold_reg     <= hold_next;
            low_flag_reg <= low_flag_next;
        end
    end

    // reset request, wake and open-drain reset pin
    assign monitor_reset = hold_reg;
    assign wake_request  = hold_reg & (wait_mode | stop_mode); // [R11] [R12]
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe  = hold_reg; // [R6]

    // bus handshakes
    assign s_axi_awready = ~aw_have_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_have_reg & ~bvalid_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign wr_fire       = aw_have_reg & w_have_reg & ~bvalid_reg;
    assign rd_fire       = s_axi_arvalid & ~rvalid_reg;
    assign wr_opt  = wr_fire && aw_addr_reg == LSRM_ADDR_OPTION && w_strb_reg[0];
    assign wr_mask = wr_fire && aw_addr_reg == LSRM_ADDR_MASK && w_strb_reg[0];

    // write channel capture and response
    always_comb begin
        aw_have_next = aw_have_reg;
        aw_addr_next = aw_addr_reg;
        w_have_next  = w_have_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_next = 1'b1;
            aw_addr_next = {s_axi_awaddr[3:2], 2'h0};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            // status and event are read-only, writes there are ignored
            unique case (aw_addr_reg)
                LSRM_ADDR_OPTION,
                LSRM_ADDR_STATUS,
                LSRM_ADDR_EVENT,
                LSRM_ADDR_MASK: bresp_next = LSRM_RESP_OKAY; // [R9]
                default:        bresp_next = LSRM_RESP_SLVERR;
            endcase
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_have_reg  <= 1'b0;
            w_data_reg  <= 32'h0;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= LSRM_RESP_OKAY;
        end else begin
            aw_have_reg <= aw_have_next;
            aw_addr_reg <= aw_addr_next;
            w_have_reg  <= w_have_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
        end
    end

    // read channel: data one cycle after address taken
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rd_fire) begin
            rvalid_next = 1'b1;
            rdata_next  = 32'h0;
            rresp_next  = LSRM_RESP_OKAY;
            unique case ({s_axi_araddr[3:2], 2'h0})
                LSRM_ADDR_OPTION: rdata_next[2:0] = option_reg;
                LSRM_ADDR_STATUS: begin
                    rdata_next[LSRM_BIT_LOW_FLAG] = low_flag_reg;
                    rdata_next[LSRM_BIT_HOLD]     = hold_reg;
                    rdata_next[LSRM_BIT_BELOW]    = below_s;
                    rdata_next[LSRM_BIT_ABOVE]    = above_s;
                end
                LSRM_ADDR_EVENT:  rdata_next[1:0] = event_reg;
                LSRM_ADDR_MASK:   rdata_next[1:0] = mask_reg;
                default:          rresp_next = LSRM_RESP_SLVERR;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0;
            rresp_reg  <= LSRM_RESP_OKAY;
        end else begin
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

    // event bits: flag rising and monitor reset entry
    assign event_set[LSRM_EV_FLAG_SET] = low_flag_next & ~low_flag_reg;
    assign event_set[LSRM_EV_RESET]    = hold_next & ~hold_reg;

    // option, event and mask registers; a set beats a read clear
    always_comb begin
        option_next = option_reg;
        mask_next   = mask_reg;
        event_next  = event_reg;
        if (wr_opt) begin
            option_next = w_data_reg[2:0];
        end
        if (wr_mask) begin
            mask_next = w_data_reg[1:0];
        end
        if (rd_fire && {s_axi_araddr[3:2], 2'h0} == LSRM_ADDR_EVENT) begin
            event_next = 2'h0;
        end
        event_next = event_next | event_set;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            option_reg <= LSRM_OPTION_RST; // [R1]
            mask_reg   <= LSRM_MASK_RST;
            event_reg  <= LSRM_EVENT_RST;
        end else begin
            option_reg <= option_next;
            mask_reg   <= mask_next;
            event_reg  <= event_next;
        end
    end

    // system event line, not a processor interrupt request
    assign event_irq = |(event_reg & mask_reg); // [R10]

endmodule
`default_nettype wire

// >>> lsrm_supply_model.sv
`timescale 1ns/100ps
`default_nettype none
module lsrm_supply_model (
    input  wire logic [1:0] supply_level,
    output logic            below_falling,
    output logic            above_rising,
    output logic            crystal_clock
);
    // crystal runs free, slower than half the cpu clock, phase unrelated
    initial begin
        crystal_clock = 1'b0;
        forever #170 crystal_clock = ~crystal_clock;
    end
    // level 0 is under falling trip, 1 between trips, 2 healthy
    assign below_falling = (supply_level == 2'h0);
    assign above_rising  = (supply_level == 2'h2);
endmodule
`default_nettype wire

// >>> lsrm_monitor_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module lsrm_monitor_asserts (
    input wire logic clock,
    input wire logic reset,
    input wire logic below_falling,
    input wire logic above_rising,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic monitor_reset,
    input wire logic wake_request,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    logic [3:0] low_run_reg;
    logic [3:0] low_run_next;
    // saturating run length of the raw low-supply level
    always_comb begin
        low_run_next = !below_falling ? 4'h0 :
            (&low_run_reg) ? 4'hF : low_run_reg + 4'h1;
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            low_run_reg <= 4'h0;
        end else begin
            low_run_reg <= low_run_next;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // the raw run must have reached 9 three edges before the rise;
    // two sync stages and the hold register sit between pin and output
    rst_filter_a: assert property ($rose(monitor_reset) |->
        $past(low_run_reg, 3) >= 4'h9) else $error("reset after short dip");
    pin_low_a: assert property (reset_pin_out == 1'b0)
        else $error("reset pin driven high");
    pin_follow_a: assert property (reset_pin_oe == monitor_reset)
        else $error("reset pin not tied to monitor reset");
    wake_req_a: assert property (wake_request ==
        (monitor_reset && (wait_mode || stop_mode))) else $error("wake");
    reset_release_a: assert property (above_rising [*7] |->
        !monitor_reset) else $error("reset not released");
    reset_hold_a: assert property (monitor_reset && !above_rising &&
        !$past(above_rising) && !$past(above_rising, 2) |=> monitor_reset)
        else $error("reset dropped early");
    bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("write response repeated");
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    cover property ($rose(monitor_reset));
    cover property (wake_request);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind lsrm_monitor lsrm_monitor_asserts asserts_u (.*);
`default_nettype wire

// >>> test_low_supply_reset_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module test_low_supply_reset_monitor;
    import lsrm_pkg::*;
    typedef struct {
        logic        wr;
        logic [3:0]  a;
        logic [31:0] d;
        logic [31:0] q;
    } lsrm_row_t;
    logic        clock, reset, wait_mode, stop_mode, monitor_reset;
    logic        wake_request, reset_pin_out, reset_pin_oe, event_irq;
    logic        below_falling, above_rising, crystal_clock;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, supply_level;
    logic [1:0]  wr_resp, rd_resp;
    int          miscompares = 0;
    int          check_count = 0;
    lsrm_row_t   rows [8];
    lsrm_monitor dut_u (.*);
    lsrm_supply_model model_u (.*);
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // bus write: address and data offered together, released when taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (n < 40 && !s_axi_bvalid);
        wr_resp = s_axi_bresp;
        if (!s_axi_bvalid) begin
            miscompares++;
            stop_test();
        end
    endtask
    task automatic axi_rd(input logic [3:0] a);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (n < 40 && !s_axi_rvalid);
        rd = s_axi_rdata;
        rd_resp = s_axi_rresp;
        if (!s_axi_rvalid) begin
            miscompares++;
            stop_test();
        end
    endtask
    task automatic run(input logic [1:0] lvl, input int cycles);
        supply_level <= lvl;
        repeat (cycles) @(posedge clock);
    endtask
    task automatic flag_is(input logic e);
        axi_rd(LSRM_ADDR_STATUS);
        check("supply_low_flag", 32'(rd[LSRM_BIT_LOW_FLAG]), 32'(e));
    endtask
    initial begin
        {reset, wait_mode, stop_mode, supply_level} = 5'h12;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        rows = '{'{1'b0, LSRM_ADDR_OPTION, 32'h0, 32'h0},
                 '{1'b0, LSRM_ADDR_EVENT, 32'h0, 32'h0},
                 '{1'b0, LSRM_ADDR_MASK, 32'h0, 32'h0},
                 '{1'b1, LSRM_ADDR_OPTION, 32'h7, 32'h7},
                 '{1'b1, LSRM_ADDR_OPTION, 32'h0, 32'h0},
                 '{1'b1, LSRM_ADDR_STATUS, 32'hF, 32'h8},
                 '{1'b1, LSRM_ADDR_EVENT, 32'h3, 32'h0},
                 '{1'b1, LSRM_ADDR_MASK, 32'h3, 32'h3}};
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        // register rows: reset values, read back, read-only places
        for (int i = 0; i < 8; i++) begin
            if (rows[i].wr) axi_wr(rows[i].a, rows[i].d);
            axi_rd(rows[i].a);
            check("register", rd, rows[i].q);
            check("rresp", 32'(rd_resp), 32'(LSRM_RESP_OKAY));
            if (rows[i].wr) begin
                check("bresp", 32'(wr_resp), 32'(LSRM_RESP_OKAY));
            end
        end
        $display("test registers done");
        run(2'h0, 8);
        run(2'h2, 20);
        check("short dip", 32'(monitor_reset), 32'h0);
        wait_mode <= 1'b1;
        run(2'h0, 10);
        check("early reset", 32'(monitor_reset), 32'h0);
        run(2'h0, 4);
        check("reset", 32'(monitor_reset), 32'h1);
        check("pin drive", 32'(reset_pin_oe), 32'h1);
        check("pin level", 32'(reset_pin_out), 32'h0);
        check("wake", 32'(wake_request), 32'h1);
        run(2'h1, 10);
        check("held", 32'(monitor_reset), 32'h1);
        check("irq", 32'(event_irq), 32'h1);
        axi_rd(LSRM_ADDR_EVENT);
        check("event", rd, 32'h2);
        repeat (2) @(posedge clock);
        check("irq clear", 32'(event_irq), 32'h0);
        run(2'h2, 6);
        check("released", 32'(monitor_reset), 32'h0);
        wait_mode <= 1'b0;
        $display("test forced reset done");
        axi_wr(LSRM_ADDR_OPTION, 32'h2);
        run(2'h0, 100);
        flag_is(1'b0);
        run(2'h0, 45);
        flag_is(1'b1);
        check("no reset", 32'(monitor_reset), 32'h0);
        check("flag irq", 32'(event_irq), 32'h1);
        axi_rd(LSRM_ADDR_EVENT);
        check("flag event", rd, 32'h1);
        run(2'h1, 10);
        flag_is(1'b1);
        run(2'h2, 5);
        flag_is(1'b0);
        $display("test polled flag done");
        run(2'h0, 150);
        run(2'h1, 2);
        reset <= 1'b1;
        run(2'h1, 2);
        reset <= 1'b0;
        run(2'h1, 1);
        flag_is(1'b0);
        axi_wr(LSRM_ADDR_OPTION, 32'h1);
        run(2'h0, 150);
        check("off reset", 32'(monitor_reset), 32'h0);
        flag_is(1'b0);
        run(2'h2, 3);
        axi_wr(LSRM_ADDR_OPTION, 32'h0);
        stop_mode <= 1'b1;
        run(2'h0, 30);
        check("stop off", 32'(monitor_reset), 32'h0);
        axi_wr(LSRM_ADDR_OPTION, 32'h4);
        run(2'h0, 14);
        check("stop reset", 32'(monitor_reset), 32'h1);
        check("stop wake", 32'(wake_request), 32'h1);
        run(2'h2, 6);
        stop_mode <= 1'b0;
        $display("test modes done");
        stop_test();
    end
endmodule
`default_nettype wire
